// ==== hv_measure_switch_control.v ====
// Measurement switch control: routes the wake/sense pin to the fail-out/IO
// pin through an internal switch and gates both pins while measuring.
// Assumes an APB master on pclk, mode and sleep command from the chip's
// mode controller on the same clock, and asynchronous pin levels.
//
// How it works
// (RULE_01) Reset leaves measurement off, switch open, both pins ordinary.
// (RULE_02) Switch closes only in normal mode while measure_enable is set.
// (RULE_03) Leaving normal mode opens the switch but keeps measure_enable.
// (RULE_04) Measuring kills both pins' pull currents and gates their inputs.
// (RULE_05) Measuring ignores pull, wake and IO settings; writes still land.
// (RULE_06) Measuring stops wake status and level updates from both pins.
// (RULE_07) Sleep with only pin wake sources while measuring: fault, restart.
// (RULE_08) Measuring removes fail output, its test, IO and pin wake.
// (RULE_09) Changing IO configuration while measuring raises command fault.
// (RULE_10) Setting measure_enable with IO pin not off is refused with fault.
// (RULE_11) Fail-safe keeps measurement, opens switch; else wake pin armed.
// (RULE_12) Switch and gating are registered from enable and mode.
`include "hv_measure_defines.vh"
`default_nettype none

module hv_measure_switch_control (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [2:0]  op_mode,
  input  wire        sleep_cmd,
  input  wire        other_wake_en,
  input  wire        fail_assert,
  input  wire        wake_sense_pin,
  input  wire        fio_in,
  output reg         fio_out,
  output reg         fio_oe,
  output reg         measure_switch,
  output reg         wake_pull_up_en,
  output reg         wake_pull_dn_en,
  output reg         fio_pull_dn_en,
  output reg         wake_in_gated,
  output reg         fio_in_gated,
  output reg         wake_src_active,
  output reg         sleep_accept,
  output reg         restart_req,
  output reg         irq
);

  // ============================================================
  // Configuration and status storage
  reg        measure_enable_r;
  reg [4:0]  io_config_r;
  reg        wake_ctrl_one_r;
  reg [1:0]  wake_pull_r;
  reg [3:0]  irq_status_r;
  reg [3:0]  irq_enable_r;
  reg        wk_stat_zero_r;
  reg        wk_stat_one_r;
  reg [1:0]  wk_level_r;
  reg [1:0]  pin_prev_r;
  wire [1:0] pin_s;

  // Pin levels enter through two flip-flops
  sync_2ff #(
    .WIDTH (2)
  ) u_pin_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .ce    (ce),
    .d     ({fio_in, wake_sense_pin}),
    .q     (pin_s)
  );

  // ============================================================
  // APB decode
  wire       setup_ph  = psel & ~penable;
  wire       done_ph   = psel & penable & pready;
  wire       wr_en     = done_ph & pwrite;
  wire       hit_meas  = (paddr == `OFS_MEAS_CTRL);
  wire       hit_io    = (paddr == `OFS_IO_CONFIG);
  wire       hit_wk1   = (paddr == `OFS_WAKE_CTRL_ONE);
  wire       hit_pull  = (paddr == `OFS_WAKE_PULL);
  wire       hit_state = (paddr == `OFS_STATE);
  wire       hit_ists  = (paddr == `OFS_IRQ_STATUS);
  wire       hit_iclr  = (paddr == `OFS_IRQ_CLEAR);
  wire       hit_ien   = (paddr == `OFS_IRQ_ENABLE);
  wire       hit_wsts  = (paddr == `OFS_WAKE_STATUS);
  wire       mapped    = hit_meas | hit_io | hit_wk1 | hit_pull | hit_state |
                         hit_ists | hit_iclr | hit_ien | hit_wsts;

  // ============================================================
  // Derived conditions
  wire [2:0] io_sel       = io_config_r[`IO_CFG_MSB:0];
  wire       wake_pin_en  = wake_ctrl_one_r;
  wire       in_normal    = (op_mode == `MODE_NORMAL);
  wire       in_failsafe  = (op_mode == `MODE_FAILSAFE);
  // Pin wake only while not measuring; fail-safe arms the wake pin itself
  wire       wake_act     = ~measure_enable_r & (wake_pin_en | in_failsafe); // RULE_11
  wire       io_wake_act  = ~measure_enable_r & (io_sel == `IO_WAKE_IN);     // RULE_08
  wire [1:0] pin_edge     = pin_s ^ pin_prev_r;

  // Changing IO configuration while measuring
  wire       io_changed   = (pwdata[4:0] != io_config_r);
  wire       fault_io_wr  = wr_en & hit_io & measure_enable_r & io_changed; // RULE_09
  // Setting measurement with the IO pin in use is refused
  wire       meas_refuse  = wr_en & hit_meas & pwdata[`BIT_MEAS_EN] &
                            ~measure_enable_r & (io_sel != `IO_OFF);       // RULE_10
  // Sleep with only the two pin wake sources while measuring
  wire       pin_srcs     = wake_pin_en | (io_sel == `IO_WAKE_IN);
  wire       sleep_fault  = sleep_cmd & measure_enable_r & pin_srcs &
                            ~other_wake_en;                                // RULE_07

  // Events, blocked from the pins while measuring
  wire       ev_wk0       = wake_act & pin_edge[0];                        // RULE_06
  wire       ev_wk1       = io_wake_act & pin_edge[1];                     // RULE_06
  wire [3:0] ev_irq;
  assign ev_irq[`IRQ_CMD_FAULT] = fault_io_wr | meas_refuse | sleep_fault;
  assign ev_irq[`IRQ_WAKE_PIN]  = ev_wk0;
  assign ev_irq[`IRQ_IO_WAKE]   = ev_wk1;
  assign ev_irq[`IRQ_RESTART]   = sleep_fault;

  // ============================================================
  // Read data mux
  reg [31:0] rdata_nxt;
  always @*
  begin
    rdata_nxt = 32'h0000_0000;
    case (1'b1)
      hit_meas:  rdata_nxt[0]   = measure_enable_r;
      hit_io:    rdata_nxt[4:0] = io_config_r;
      hit_wk1:   rdata_nxt[0]   = wake_ctrl_one_r;
      hit_pull:  rdata_nxt[1:0] = wake_pull_r;
      hit_state: rdata_nxt[6:0] = {op_mode, wake_src_active, wake_in_gated,
                                   fio_in_gated, measure_switch};
      hit_ists:  rdata_nxt[3:0] = irq_status_r;
      hit_ien:   rdata_nxt[3:0] = irq_enable_r;
      hit_wsts:  rdata_nxt[3:0] = {wk_level_r, wk_stat_one_r, wk_stat_zero_r};
      default:   rdata_nxt = 32'h0000_0000;
    endcase
  end

  // ============================================================
  // APB answer: one wait-free access after each setup
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (ce)
    begin
      if (setup_ph)
      begin
        pready  <= 1'b1;
        pslverr <= ~mapped;
        prdata  <= pwrite ? 32'h0000_0000 : rdata_nxt;
      end
      else if (done_ph)
      begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
      end
    end
  end

  // ============================================================
  // Software configuration registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      measure_enable_r <= `RST_MEAS_EN;                                  // RULE_01
      io_config_r      <= `RST_IO_CONFIG;
      wake_ctrl_one_r  <= `RST_WAKE_CTRL_ONE;
      wake_pull_r      <= `RST_WAKE_PULL;
      irq_enable_r     <= `RST_IRQ_ENABLE;
    end
    else if (ce && wr_en)
    begin
      // Enable bit is kept across mode changes, only software moves it
      if (hit_meas && !meas_refuse)                                      // RULE_03
        measure_enable_r <= pwdata[`BIT_MEAS_EN];
      // Settings stay writable while measuring, only their effect is masked
      if (hit_io)                                                        // RULE_05
        io_config_r <= pwdata[4:0];
      if (hit_wk1)
        wake_ctrl_one_r <= pwdata[`BIT_WAKE_PIN_EN];
      if (hit_pull)
        wake_pull_r <= pwdata[1:0];
      if (hit_ien)
        irq_enable_r <= pwdata[3:0];
    end
  end

  // ============================================================
  // Sticky interrupt status; a new event beats a clear
  wire [3:0] irq_clr = (wr_en && hit_iclr) ? pwdata[3:0] : 4'h0;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_status_r <= 4'h0;
    else if (ce)
      irq_status_r <= (irq_status_r & ~irq_clr) | ev_irq;
  end

  // ============================================================
  // Wake status and level tracking, write one to clear
  wire wk_clr0 = wr_en & hit_wsts & pwdata[`BIT_WK_STAT_ZERO];
  wire wk_clr1 = wr_en & hit_wsts & pwdata[`BIT_WK_STAT_ONE];
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wk_stat_zero_r <= 1'b0;
      wk_stat_one_r  <= 1'b0;
      wk_level_r     <= 2'h0;
      pin_prev_r     <= 2'h0;
    end
    else if (ce)
    begin
      pin_prev_r     <= pin_s;
      wk_stat_zero_r <= (wk_stat_zero_r & ~wk_clr0) | ev_wk0;           // RULE_06
      wk_stat_one_r  <= (wk_stat_one_r & ~wk_clr1) | ev_wk1;            // RULE_06
      // Levels freeze while measuring
      if (!measure_enable_r)                                            // RULE_06
        wk_level_r <= pin_s;
    end
  end

  // ============================================================
  // Sleep command outcome and interrupt line
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sleep_accept <= 1'b0;
      restart_req  <= 1'b0;
      irq          <= 1'b0;
    end
    else if (ce)
    begin
      sleep_accept <= sleep_cmd & ~sleep_fault;
      restart_req  <= sleep_fault;                                       // RULE_07
      irq          <= |(irq_status_r & irq_enable_r);
    end
  end

  // ============================================================
  // Switch, pulls and gating, registered from enable and mode
  reg fio_drive_nxt;
  reg fio_level_nxt;
  always @*
  begin
    fio_drive_nxt = 1'b0;
    fio_level_nxt = 1'b0;
    if (!measure_enable_r)                                               // RULE_08
    begin
      case (io_sel)
        `IO_FAIL_OUT:
        begin
          fio_drive_nxt = fail_assert | io_config_r[`BIT_FO_TEST];
          fio_level_nxt = 1'b0;
        end
        `IO_LOW_SIDE:
        begin
          fio_drive_nxt = io_config_r[`BIT_GPIO_ON];
          fio_level_nxt = 1'b0;
        end
        `IO_HIGH_SIDE:
        begin
          fio_drive_nxt = io_config_r[`BIT_GPIO_ON];
          fio_level_nxt = 1'b1;
        end
        default:
        begin
          fio_drive_nxt = 1'b0;
          fio_level_nxt = 1'b0;
        end
      endcase
    end
  end

  // Automatic pull follows the present wake pin level
  wire pull_up_sel = (wake_pull_r == `PULL_UP) |
                     ((wake_pull_r == `PULL_AUTO) & pin_s[0]);
  wire pull_dn_sel = (wake_pull_r == `PULL_DOWN) |
                     ((wake_pull_r == `PULL_AUTO) & ~pin_s[0]);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      measure_switch  <= 1'b0;                                           // RULE_01
      wake_pull_up_en <= 1'b0;
      wake_pull_dn_en <= 1'b0;
      fio_pull_dn_en  <= 1'b0;
      wake_in_gated   <= 1'b0;
      fio_in_gated    <= 1'b0;
      wake_src_active <= 1'b0;
      fio_out         <= 1'b0;
      fio_oe          <= 1'b0;
    end
    else if (ce)
    begin
      // Closed only in normal mode; fail-safe and others hold it open
      measure_switch  <= measure_enable_r & in_normal;          // RULE_02 RULE_11 RULE_12
      wake_pull_up_en <= ~measure_enable_r & pull_up_sel;                // RULE_04
      wake_pull_dn_en <= ~measure_enable_r & pull_dn_sel;                // RULE_04
      fio_pull_dn_en  <= ~measure_enable_r & (io_sel == `IO_WAKE_IN);    // RULE_04
      wake_in_gated   <= ~measure_enable_r & pin_s[0];                   // RULE_04 RULE_12
      fio_in_gated    <= ~measure_enable_r & pin_s[1];                   // RULE_04 RULE_12
      wake_src_active <= wake_act;                                       // RULE_11
      fio_out         <= fio_level_nxt;
      fio_oe          <= fio_drive_nxt;                                  // RULE_08
    end
  end

endmodule

`default_nettype wire

// ==== hv_measure_defines.vh ====
// Constants of the high-voltage measurement switch control block:
// register offsets, field positions, reset values and mode encodings.
// Assumes it is included once per file by its bare name.
`ifndef HV_MEASURE_DEFINES_VH
`define HV_MEASURE_DEFINES_VH

// ============================================================
// Register byte offsets
`define OFS_MEAS_CTRL      8'h00
`define OFS_IO_CONFIG      8'h04
`define OFS_WAKE_CTRL_ONE  8'h08
`define OFS_WAKE_PULL      8'h0c
`define OFS_STATE          8'h10
`define OFS_IRQ_STATUS     8'h14
`define OFS_IRQ_CLEAR      8'h18
`define OFS_IRQ_ENABLE     8'h1c
`define OFS_WAKE_STATUS    8'h20

// ============================================================
// Field positions
`define BIT_MEAS_EN        0
`define IO_CFG_MSB         2
`define BIT_FO_TEST        3
`define BIT_GPIO_ON        4
`define BIT_WAKE_PIN_EN    0
`define BIT_WK_STAT_ZERO   0
`define BIT_WK_STAT_ONE    1
`define BIT_WK_LVL_WAKE    2
`define BIT_WK_LVL_IO      3
`define IRQ_CMD_FAULT      0
`define IRQ_WAKE_PIN       1
`define IRQ_IO_WAKE        2
`define IRQ_RESTART        3
`define IRQ_W              4

// ============================================================
// Reset values
`define RST_MEAS_EN        1'b0
`define RST_IO_CONFIG      5'h01
`define RST_WAKE_CTRL_ONE  1'b0
`define RST_WAKE_PULL      2'h0
`define RST_IRQ_ENABLE     4'h0

// ============================================================
// Fail-output / I/O pin configurations
`define IO_OFF             3'h0
`define IO_FAIL_OUT        3'h1
`define IO_WAKE_IN         3'h2
`define IO_LOW_SIDE        3'h3
`define IO_HIGH_SIDE       3'h4

// Wake pin pull selections
`define PULL_NONE          2'h0
`define PULL_DOWN          2'h1
`define PULL_UP            2'h2
`define PULL_AUTO          2'h3

// Chip operating modes
`define MODE_INIT          3'h0
`define MODE_NORMAL        3'h1
`define MODE_STOP          3'h2
`define MODE_SLEEP         3'h3
`define MODE_RESTART       3'h4
`define MODE_FAILSAFE      3'h5

`endif

// ==== sync_2ff.v ====
// Two flip-flop synchroniser for a group of independent pin levels.
// Assumes each bit is a slow level; no bus coherence is implied.
`default_nettype none

module sync_2ff #(
  parameter WIDTH = 2
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             ce,
  input  wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);

  // ============================================================
  // One synchroniser chain per bit
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      reg meta_r;
      reg stable_r;
      // First stage feeds only the second
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta_r   <= 1'b0;
          stable_r <= 1'b0;
        end
        else if (ce)
        begin
          meta_r   <= d[i];
          stable_r <= meta_r;
        end
      end
      assign q[i] = stable_r;
    end
  endgenerate

endmodule

`default_nettype wire

// ==== hv_measure_asserts.sv ====
// Port checker for the measurement switch control block.
// Assumes one clock pclk and asynchronous active-low presetn.
`include "hv_measure_defines.vh"
`default_nettype none
module hv_measure_asserts (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       ce,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic [2:0] op_mode,
  input wire logic       sleep_cmd,
  input wire logic       fio_oe,
  input wire logic       measure_switch,
  input wire logic       wake_pull_up_en,
  input wire logic       wake_pull_dn_en,
  input wire logic       fio_pull_dn_en,
  input wire logic       wake_in_gated,
  input wire logic       fio_in_gated,
  input wire logic       sleep_accept,
  input wire logic       restart_req,
  input wire logic       irq
);
  // ========
  // Clocking
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ========
  // Properties
  reset_idle_a:
    assert property ($rose(presetn) |-> !measure_switch && !irq && !pready)
      else $error("outputs busy after reset");
  switch_mode_a:
    assert property ($past(ce) && measure_switch |-> $past(op_mode) == `MODE_NORMAL)
      else $error("switch closed outside normal mode");
  leave_normal_a:
    assert property (ce && op_mode != `MODE_NORMAL |=> !measure_switch)
      else $error("switch stays closed after mode change");
  pull_off_a:
    assert property (measure_switch |-> !(wake_pull_up_en || wake_pull_dn_en || fio_pull_dn_en))
      else $error("pull current on while measuring");
  inputs_gated_a:
    assert property (measure_switch |-> !wake_in_gated && !fio_in_gated)
      else $error("pin input passes while measuring");
  no_fail_out_a:
    assert property (measure_switch |-> !fio_oe)
      else $error("pin driven while measuring");
  sleep_answer_a:
    assert property (ce && sleep_cmd |=> sleep_accept != restart_req)
      else $error("sleep request not answered once");
  no_stray_a:
    assert property (ce && !sleep_cmd |=> !sleep_accept && !restart_req)
      else $error("sleep answer without request");
  apb_answer_a:
    assert property (ce && psel && !penable |=> pready ##1 !pready)
      else $error("bus answer not one cycle");
endmodule

bind hv_measure_switch_control hv_measure_asserts chk_i (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .op_mode(op_mode), .sleep_cmd(sleep_cmd),
  .fio_oe(fio_oe), .measure_switch(measure_switch), .wake_pull_up_en(wake_pull_up_en),
  .wake_pull_dn_en(wake_pull_dn_en), .fio_pull_dn_en(fio_pull_dn_en),
  .wake_in_gated(wake_in_gated), .fio_in_gated(fio_in_gated),
  .sleep_accept(sleep_accept), .restart_req(restart_req), .irq(irq)
);
`default_nettype wire

// ==== hv_measure_switch_control_bench.sv ====
// Self-checking bench for the measurement switch control block.
// Assumes the design files and the checker are compiled before it.
`include "hv_measure_defines.vh"
`default_nettype none
module hv_measure_switch_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0]  op_mode = `MODE_NORMAL;
  logic        sleep_cmd = 1'b0;
  logic        other_wake_en = 1'b0;
  logic        fail_assert = 1'b1;
  logic        wake_sense_pin = 1'b0;
  logic        fio_in = 1'b0;
  wire  [31:0] prdata;
  wire         pready, pslverr, fio_out, fio_oe, measure_switch, irq;
  wire         wake_pull_up_en, wake_pull_dn_en, fio_pull_dn_en;
  wire         wake_in_gated, fio_in_gated, wake_src_active, sleep_accept, restart_req;
  logic [31:0] rd;
  logic        err;
  int          n_errors = 0;
  int          n_compared = 0;

  hv_measure_switch_control dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_mode(op_mode), .sleep_cmd(sleep_cmd),
    .other_wake_en(other_wake_en), .fail_assert(fail_assert),
    .wake_sense_pin(wake_sense_pin), .fio_in(fio_in), .fio_out(fio_out), .fio_oe(fio_oe),
    .measure_switch(measure_switch), .wake_pull_up_en(wake_pull_up_en),
    .wake_pull_dn_en(wake_pull_dn_en), .fio_pull_dn_en(fio_pull_dn_en),
    .wake_in_gated(wake_in_gated), .fio_in_gated(fio_in_gated),
    .wake_src_active(wake_src_active), .sleep_accept(sleep_accept),
    .restart_req(restart_req), .irq(irq)
  );

  // ========
  // Clock
  always #5 pclk = ~pclk;

  // ========
  // Compare, verdict and bus tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude;
    if (n_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Wait for the answer; only the watchdog ends a hang
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic sleep_pulse;
    @(posedge pclk);
    sleep_cmd <= 1'b1;
    @(posedge pclk);
    sleep_cmd <= 1'b0;
    #1;
  endtask

  // ========
  // Watchdog
  initial
  begin
    #50us;
    n_errors++;
    conclude();
  end

  // ========
  // Main sequence
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    settle(3);
    chk("switch", measure_switch, 32'h0);
    chk("fail_oe", fio_oe, 32'h1);
    rdc("meas", `OFS_MEAS_CTRL, 32'h0);
    rdc("io", `OFS_IO_CONFIG, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    apb(1'b1, `OFS_IRQ_ENABLE, 32'hf);
    apb(1'b1, `OFS_MEAS_CTRL, 32'h1);
    rdc("meas_refused", `OFS_MEAS_CTRL, 32'h0);
    rdc("fault", `OFS_IRQ_STATUS, 32'h1);
    settle(2);
    chk("irq", irq, 32'h1);
    apb(1'b1, `OFS_IRQ_ENABLE, 32'h0);
    settle(2);
    chk("irq_masked", irq, 32'h0);
    apb(1'b1, `OFS_IRQ_CLEAR, 32'hf);
    rdc("cleared", `OFS_IRQ_STATUS, 32'h0);
    // Enable measuring with the pin off
    apb(1'b1, `OFS_WAKE_PULL, 32'h2);
    apb(1'b1, `OFS_IO_CONFIG, 32'h0);
    apb(1'b1, `OFS_MEAS_CTRL, 32'h1);
    settle(2);
    chk("switch_on", measure_switch, 32'h1);
    chk("pulls", {wake_pull_up_en, wake_pull_dn_en, fio_pull_dn_en}, 32'h0);
    rdc("pull_kept", `OFS_WAKE_PULL, 32'h2);
    apb(1'b1, `OFS_IO_CONFIG, 32'h9);
    rdc("io_kept", `OFS_IO_CONFIG, 32'h9);
    rdc("io_fault", `OFS_IRQ_STATUS, 32'h1);
    chk("no_fail_out", fio_oe, 32'h0);
    // Wake pin armed so that the ungated wake pin would raise events
    apb(1'b1, `OFS_WAKE_CTRL_ONE, 32'h1);
    wake_sense_pin <= 1'b1;
    fio_in <= 1'b1;
    settle(5);
    chk("gated", {wake_in_gated, fio_in_gated}, 32'h0);
    rdc("wake_stat", `OFS_WAKE_STATUS, 32'h0);
    rdc("no_wake_irq", `OFS_IRQ_STATUS, 32'h1);
    // Sleep with only pin wake sources
    apb(1'b1, `OFS_IRQ_CLEAR, 32'hf);
    sleep_pulse();
    chk("restart", restart_req, 32'h1);
    rdc("sleep_fault", `OFS_IRQ_STATUS, 32'h9);
    other_wake_en <= 1'b1;
    sleep_pulse();
    chk("accept", {sleep_accept, restart_req}, 32'h2);
    // Mode changes while measuring; clock enable low freezes the switch
    ce <= 1'b0;
    op_mode <= `MODE_STOP;
    settle(3);
    chk("frozen", measure_switch, 32'h1);
    ce <= 1'b1;
    settle(2);
    chk("stop_open", measure_switch, 32'h0);
    rdc("meas_held", `OFS_MEAS_CTRL, 32'h1);
    op_mode <= `MODE_NORMAL;
    settle(2);
    chk("resume", measure_switch, 32'h1);
    op_mode <= `MODE_FAILSAFE;
    settle(2);
    chk("fs_open", {measure_switch, wake_src_active}, 32'h0);
    rdc("fs_kept", `OFS_MEAS_CTRL, 32'h1);
    op_mode <= `MODE_NORMAL;
    apb(1'b1, `OFS_MEAS_CTRL, 32'h0);
    settle(2);
    chk("pull_back", wake_pull_up_en, 32'h1);
    chk("ungated", {wake_in_gated, fio_in_gated}, 32'h3);
    chk("fail_back", {fio_oe, fio_out}, 32'h2);
    // Fail-safe must arm the wake pin by itself
    apb(1'b1, `OFS_WAKE_CTRL_ONE, 32'h0);
    settle(2);
    chk("wake_off", wake_src_active, 32'h0);
    op_mode <= `MODE_FAILSAFE;
    settle(3);
    chk("fs_wake", wake_src_active, 32'h1);
    wake_sense_pin <= 1'b0;
    settle(5);
    rdc("fs_event", `OFS_WAKE_STATUS, 32'h9);
    rdc("fs_irq", `OFS_IRQ_STATUS, 32'hb);
    // Pin functions return once measuring is off
    apb(1'b1, `OFS_IO_CONFIG, 32'h14);
    settle(2);
    chk("high_side", {fio_oe, fio_out}, 32'h3);
    apb(1'b1, `OFS_IO_CONFIG, 32'h2);
    settle(2);
    chk("io_pull", fio_pull_dn_en, 32'h1);
    conclude();
  end
endmodule
`default_nettype wire
